//--- hw/rsm_pkg.sv
/*
 * Package for the radio link SPI master port: register addresses,
 * reset values, field positions, FIFO sizing and serial timing.
 * Assumes an 8-bit special-function-register bus on the core clock.
 */
package rsm_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] RSM_ADDR_RSV_CFG  = 8'he4;
    localparam logic [7:0] RSM_ADDR_IRQ_MASK = 8'he5;
    localparam logic [7:0] RSM_ADDR_FLAGS    = 8'he6;
    localparam logic [7:0] RSM_ADDR_DATA     = 8'he7;
    localparam logic [7:0] RSM_ADDR_PIN_CTRL = 8'he8;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [6:0] RSM_RSV_CFG_RST  = 7'h01;
    localparam logic [3:0] RSM_IRQ_MASK_RST = 4'hf;
    localparam logic [7:0] RSM_FLAGS_RST    = 8'h03;
    localparam logic [7:0] RSM_DATA_RST     = 8'h00;
    localparam logic [2:0] RSM_PIN_CTRL_RST = 3'h2;

    // ------------------------------------------------------------
    // Pin control field positions
    // ------------------------------------------------------------
    localparam int RSM_CTRL_CE_BIT   = 0;
    localparam int RSM_CTRL_CSN_BIT  = 1;
    localparam int RSM_CTRL_TRANSCEIVER_CLOCK_GATE_BIT = 2;

    // ------------------------------------------------------------
    // FIFO and serial timing
    // ------------------------------------------------------------
    localparam int         RSM_BYTE_W       = 8;
    localparam int         RSM_FIFO_DEPTH   = 2;
    localparam int         RSM_CORE_NS      = 10;
    localparam int         RSM_SCLK_HALF_NS = 40;
    localparam logic [2:0] RSM_SCLK_HALF_CYC =
        3'(RSM_SCLK_HALF_NS / RSM_CORE_NS);
    localparam logic [2:0] RSM_LAST_BIT     = 3'h7;

    // Live status flags, ordered as in the flag register
    typedef struct packed {
        logic rx_full_flag;
        logic rx_avail_flag;
        logic tx_empty_flag;
        logic tx_space_flag;
    } rsm_flags_t;

    // Pins towards the transceiver
    typedef struct packed {
        logic sclk;
        logic mosi;
        logic slave_select_n;
        logic chip_enable;
        logic transceiver_clock_gate;
    } rsm_pins_t;

    typedef enum logic [1:0] {
        RSM_ST_IDLE,
        RSM_ST_LOW,
        RSM_ST_HIGH
    } rsm_state_t;

endpackage

//--- hw/rsm_byte_fifo.sv
/*
 * Small synchronous byte FIFO used for both directions of the port.
 * Assumes the caller never pushes when full nor pops when empty.
 */
`timescale 1ns/100ps
module rsm_byte_fifo
#(
    parameter int WIDTH = rsm_pkg::RSM_BYTE_W,
    parameter int DEPTH = rsm_pkg::RSM_FIFO_DEPTH
)
(
    input  wire logic             core_clk_in,   // Core clock
    input  wire logic             rst_n_in,      // Async reset, low
    input  wire logic             push_in,       // Write one entry
    input  wire logic [WIDTH-1:0] push_data_in,  // Entry written
    input  wire logic             pop_in,        // Drop head entry
    output logic      [WIDTH-1:0] head_out,      // Head entry
    output logic      [1:0]       count_out      // Entries held
);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic             wr_ptr_q;
    logic             rd_ptr_q;
    logic [1:0]       count_q;

    // ------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in)
    begin
        if (push_in)
        begin
            mem_q[wr_ptr_q] <= push_data_in;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end
        else
        begin
            if (push_in)
                wr_ptr_q <= ~wr_ptr_q;
            if (pop_in)
                rd_ptr_q <= ~rd_ptr_q;
            if (push_in && !pop_in)
                count_q <= count_q + 2'h1;
            else if (pop_in && !push_in)
                count_q <= count_q - 2'h1;
        end
    end

    assign head_out  = (count_q == 2'h0) ? '0 : mem_q[rd_ptr_q];
    assign count_out = count_q;

endmodule // rsm_byte_fifo

//--- hw/rsm_radio_spi_port.sv
/*
 * SPI master port to the on-chip radio transceiver and its registers.
 * Assumes a one-cycle SFR bus on the core clock; slave shifts on fall.
 */
// Function
// RL1: Four mask bits, one disables, reset all ones
// RL2: Interrupt when an unmasked source is active
// RL3: Read-only flags, reset 0x03, follow live state
// RL4: Bit 3 set while receive FIFO full
// RL5: Bit 2 set while receive FIFO holds data
// RL6: Bit 0 free transmit slot, bit 1 empty
// RL7: Data write pushes transmit, read pops receive
// RL8: Software obeys flags before writing or reading
// RL9: Software leaves the reserved register alone
// RL10: Control bit 2 gates the radio clock
// RL11: Control bit 1 drives slave select directly
// RL12: Control bit 0 drives chip enable directly
// RL13: Retry limit event is reported, payload kept
// RL14: Software toggles chip enable or flushes
// RL15: Software lowers select before each command
// RL16: First received byte readable from data register
// RL17: Bytes shifted most significant bit first
// RL18: Each transmit byte is one full-duplex exchange
`timescale 1ns/100ps
module rsm_radio_spi_port
(
    input  wire logic       core_clk_in,         // Core clock, 100 MHz
    input  wire logic       rst_n_in,            // Async reset, low
    input  wire logic [7:0] sfr_addr_in,         // Register address
    input  wire logic       sfr_wr_in,           // Write strobe
    input  wire logic       sfr_rd_in,           // Read strobe
    input  wire logic [7:0] sfr_wdata_in,        // Write data
    output logic      [7:0] sfr_rdata_out,       // Read data, next cycle
    input  wire logic       spi_miso_in,         // Serial data in
    input  wire logic       retry_limit_irq_in,  // Transceiver event
    output logic            spi_sclk_out,        // Serial clock
    output logic            spi_mosi_out,        // Serial data out
    output logic            slave_select_n_out,  // Slave select, low
    output logic            chip_enable_out,     // Transceiver enable
    output logic            clock_gate_out,      // Radio clock gate
    output logic            retry_limit_out,     // Retry limit level
    output logic            irq_out              // Port interrupt
);

    logic [6:0]          rsv_cfg_q;
    logic [3:0]          mask_q;
    logic [2:0]          ctrl_q;
    logic [7:0]          rdata_q;
    logic                irq_q;
    logic [1:0]          miso_sync_q;
    logic [1:0]          retry_sync_q;
    rsm_pkg::rsm_state_t state_q;
    logic [2:0]          half_cnt_q;
    logic [2:0]          bit_cnt_q;
    logic [7:0]          tx_shift_q;
    logic [7:0]          rx_shift_q;
    rsm_pkg::rsm_pins_t  pins;
    rsm_pkg::rsm_flags_t radio_link_flag_set;
    logic [7:0]          tx_head;
    logic [7:0]          rx_head;
    logic [1:0]          tx_count;
    logic [1:0]          rx_count;
    logic                wr_data;
    logic                rd_data;
    logic                tx_push;
    logic                rx_pop;
    logic                start;
    logic                half_done;
    logic                rx_push;
    logic [7:0]          rx_byte;
    logic                sclk_q;
    logic                mosi_q;

    // ------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------
    assign wr_data = sfr_wr_in && (sfr_addr_in == rsm_pkg::RSM_ADDR_DATA);
    assign rd_data = sfr_rd_in && (sfr_addr_in == rsm_pkg::RSM_ADDR_DATA);
    assign tx_push = wr_data && (tx_count != 2'(rsm_pkg::RSM_FIFO_DEPTH));
    assign rx_pop  = rd_data && (rx_count != 2'h0);                 // see RL7

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rsv_cfg_q <= rsm_pkg::RSM_RSV_CFG_RST;
            mask_q    <= rsm_pkg::RSM_IRQ_MASK_RST;                 // see RL1
            ctrl_q    <= rsm_pkg::RSM_PIN_CTRL_RST;
        end
        else if (sfr_wr_in)
        begin
            case (sfr_addr_in)
                rsm_pkg::RSM_ADDR_RSV_CFG:  rsv_cfg_q <= sfr_wdata_in[6:0];
                rsm_pkg::RSM_ADDR_IRQ_MASK: mask_q <= sfr_wdata_in[3:0];
                rsm_pkg::RSM_ADDR_PIN_CTRL: ctrl_q <= sfr_wdata_in[2:0];
                default: ;
            endcase
        end
    end

    assign radio_link_flag_set.rx_full_flag =
        (rx_count == 2'(rsm_pkg::RSM_FIFO_DEPTH));                  // see RL4
    assign radio_link_flag_set.rx_avail_flag = (rx_count != 2'h0);  // see RL5
    assign radio_link_flag_set.tx_empty_flag = (tx_count == 2'h0);  // see RL6
    assign radio_link_flag_set.tx_space_flag =
        (tx_count != 2'(rsm_pkg::RSM_FIFO_DEPTH));                  // see RL6

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rdata_q <= rsm_pkg::RSM_DATA_RST;
        else if (sfr_rd_in)
        begin
            case (sfr_addr_in)
                rsm_pkg::RSM_ADDR_RSV_CFG:  rdata_q <= {1'b0, rsv_cfg_q};
                rsm_pkg::RSM_ADDR_IRQ_MASK: rdata_q <= {4'h0, mask_q};
                rsm_pkg::RSM_ADDR_FLAGS:                            // see RL3
                    rdata_q <= {4'h0, radio_link_flag_set};
                rsm_pkg::RSM_ADDR_DATA:     rdata_q <= rx_head;     // see RL16
                rsm_pkg::RSM_ADDR_PIN_CTRL: rdata_q <= {5'h00, ctrl_q};
                default:                    rdata_q <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupt and input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            irq_q <= 1'b0;
        else
            irq_q <= |(radio_link_flag_set & ~mask_q);              // see RL2
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            miso_sync_q  <= 2'h0;
            retry_sync_q <= 2'h0;
        end
        else
        begin
            miso_sync_q  <= {miso_sync_q[0], spi_miso_in};
            retry_sync_q <= {retry_sync_q[0], retry_limit_irq_in};  // see RL13
        end
    end

    // ------------------------------------------------------------
    // FIFOs
    // ------------------------------------------------------------
    rsm_byte_fifo u_tx_fifo
    (
        .core_clk_in  (core_clk_in),
        .rst_n_in     (rst_n_in),
        .push_in      (tx_push),
        .push_data_in (sfr_wdata_in),
        .pop_in       (start),
        .head_out     (tx_head),
        .count_out    (tx_count)
    );

    rsm_byte_fifo u_rx_fifo
    (
        .core_clk_in  (core_clk_in),
        .rst_n_in     (rst_n_in),
        .push_in      (rx_push),
        .push_data_in (rx_byte),
        .pop_in       (rx_pop),
        .head_out     (rx_head),
        .count_out    (rx_count)
    );

    // ------------------------------------------------------------
    // Serial engine
    // ------------------------------------------------------------
    // Exchange waits while the receive side is full so no byte is lost
    assign start = (state_q == rsm_pkg::RSM_ST_IDLE) &&
                   (tx_count != 2'h0) &&
                   !radio_link_flag_set.rx_full_flag;               // see RL18
    assign half_done = (half_cnt_q == rsm_pkg::RSM_SCLK_HALF_CYC - 3'h1);
    assign rx_byte   = {rx_shift_q[6:0], miso_sync_q[1]};
    assign rx_push   = (state_q == rsm_pkg::RSM_ST_HIGH) && half_done &&
                       (bit_cnt_q == rsm_pkg::RSM_LAST_BIT);        // see RL18

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_q    <= rsm_pkg::RSM_ST_IDLE;
            half_cnt_q <= 3'h0;
            bit_cnt_q  <= 3'h0;
        end
        else
        begin
            case (state_q)
                rsm_pkg::RSM_ST_IDLE:
                begin
                    half_cnt_q <= 3'h0;
                    bit_cnt_q  <= 3'h0;
                    if (start)
                        state_q <= rsm_pkg::RSM_ST_LOW;
                end
                rsm_pkg::RSM_ST_LOW:
                begin
                    half_cnt_q <= half_done ? 3'h0 : half_cnt_q + 3'h1;
                    if (half_done)
                        state_q <= rsm_pkg::RSM_ST_HIGH;
                end
                rsm_pkg::RSM_ST_HIGH:
                begin
                    half_cnt_q <= half_done ? 3'h0 : half_cnt_q + 3'h1;
                    if (half_done)
                    begin
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        state_q   <= rx_push ? rsm_pkg::RSM_ST_IDLE
                                             : rsm_pkg::RSM_ST_LOW;
                    end
                end
                default:
                    state_q <= rsm_pkg::RSM_ST_IDLE;
            endcase
        end
    end

    // Data moves on the falling edge and is sampled at the end of high
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            tx_shift_q <= 8'h00;
            rx_shift_q <= 8'h00;
        end
        else if (start)
            tx_shift_q <= tx_head;                                  // see RL17
        else if ((state_q == rsm_pkg::RSM_ST_HIGH) && half_done)
        begin
            tx_shift_q <= {tx_shift_q[6:0], 1'b0};                  // see RL17
            rx_shift_q <= rx_byte;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sclk_q <= 1'b0;
            mosi_q <= 1'b0;
        end
        else
        begin
            sclk_q <= (state_q == rsm_pkg::RSM_ST_LOW) ? half_done :
                      (state_q == rsm_pkg::RSM_ST_HIGH) && !half_done;
            if (start)
                mosi_q <= tx_head[7];                               // see RL17
            else if ((state_q == rsm_pkg::RSM_ST_HIGH) && half_done)
                mosi_q <= tx_shift_q[6];
        end
    end

    assign pins.sclk = sclk_q;
    assign pins.mosi = mosi_q;
    assign pins.slave_select_n = ctrl_q[rsm_pkg::RSM_CTRL_CSN_BIT]; // see RL11
    assign pins.chip_enable = ctrl_q[rsm_pkg::RSM_CTRL_CE_BIT];     // see RL12
    assign pins.transceiver_clock_gate =
        ctrl_q[rsm_pkg::RSM_CTRL_TRANSCEIVER_CLOCK_GATE_BIT];                         // see RL10

    assign spi_sclk_out       = pins.sclk;
    assign spi_mosi_out       = pins.mosi;
    assign slave_select_n_out = pins.slave_select_n;
    assign chip_enable_out    = pins.chip_enable;
    assign clock_gate_out     = pins.transceiver_clock_gate;
    assign retry_limit_out    = retry_sync_q[1];
    assign irq_out            = irq_q;
    assign sfr_rdata_out      = rdata_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_mask_write: assert property (                                 // see RL1
        sfr_wr_in && sfr_addr_in == rsm_pkg::RSM_ADDR_IRQ_MASK
        |=> mask_q == $past(sfr_wdata_in[3:0]))
        else $error("mask register not updated");
    a_irq_unmasked: assert property (                               // see RL2
        |(radio_link_flag_set & ~mask_q) |=> irq_out)
        else $error("unmasked source gave no interrupt");
    a_flag_read: assert property (                                  // see RL3
        sfr_rd_in && sfr_addr_in == rsm_pkg::RSM_ADDR_FLAGS
        |=> sfr_rdata_out == {4'h0, $past(radio_link_flag_set)})
        else $error("flag read differs from live state");
    a_rx_full_flag: assert property (                               // see RL4
        rx_push && rx_count == 2'h1 && !rx_pop
        |=> radio_link_flag_set.rx_full_flag)
        else $error("receive full flag missing");
    a_rx_avail_pop: assert property (                               // see RL5
        rx_pop && rx_count == 2'h1 && !rx_push
        |=> !radio_link_flag_set.rx_avail_flag)
        else $error("data flag stays after last pop");
    a_tx_fill: assert property (                                    // see RL6
        tx_push && tx_count == 2'h1 && !start
        |=> !radio_link_flag_set.tx_space_flag &&
            !radio_link_flag_set.tx_empty_flag)
        else $error("transmit flags wrong when full");
    a_rx_pop_count: assert property (                               // see RL7
        rx_pop && !rx_push |=> rx_count == $past(rx_count) - 2'h1)
        else $error("data read did not pop");
    a_clock_gate: assert property (                                 // see RL10
        sfr_wr_in && sfr_addr_in == rsm_pkg::RSM_ADDR_PIN_CTRL
        |=> clock_gate_out == $past(sfr_wdata_in[2]))
        else $error("clock gate not following control");
    a_select_pin: assert property (                                 // see RL11
        sfr_wr_in && sfr_addr_in == rsm_pkg::RSM_ADDR_PIN_CTRL
        |=> slave_select_n_out == $past(sfr_wdata_in[1]))
        else $error("select not following control");
    a_enable_pin: assert property (                                 // see RL12
        sfr_wr_in && sfr_addr_in == rsm_pkg::RSM_ADDR_PIN_CTRL
        |=> chip_enable_out == $past(sfr_wdata_in[0]))
        else $error("enable not following control");
    a_retry_level: assert property (                                // see RL13
        $rose(retry_limit_irq_in) ##1 retry_limit_irq_in [*2]
        |=> retry_limit_out)
        else $error("retry limit not reported");
    a_msb_first: assert property (                                  // see RL17
        start |=> spi_mosi_out == $past(tx_head[7]))
        else $error("first bit not most significant");
    a_byte_exchange: assert property (                              // see RL18
        start |-> ##64 rx_push)
        else $error("exchange length wrong");
    c_exchange:  cover property (start ##64 rx_push);
    c_rx_full:   cover property (radio_link_flag_set.rx_full_flag);
    c_irq:       cover property ($rose(irq_out));
    c_back2back: cover property (rx_push ##1 start);

endmodule // rsm_radio_spi_port

//--- sim/rsm_radio_model.sv
/*
 * Behavioural transceiver SPI slave facing the radio link port.
 * Assumes the port drives the serial clock and samples MISO at the
 * end of each high phase; this model shifts out on the falling edge.
 */
`timescale 1ns/100ps
module rsm_radio_model
(
    input  wire logic       sclk_in,            // Serial clock
    input  wire logic       mosi_in,            // Serial data from port
    input  wire logic       slave_select_n_in,  // Select, low
    input  wire logic       chip_enable_in,     // Transceiver enable
    input  wire logic [7:0] reply_in,           // Next byte returned
    input  wire logic       fire_retry_in,      // Raise retry event
    output logic            miso_out,           // Serial data to port
    output logic            retry_irq_out,      // Retry limit level
    output logic            byte_done_out,      // Byte taken, pulse
    output logic      [7:0] rx_byte_out         // Last byte taken
);
    logic [7:0] tx_q;
    logic [7:0] sh_q;
    logic [2:0] cnt_q;

    initial
    begin
        tx_q = 8'h00;
        sh_q = 8'h00;
        cnt_q = 3'h0;
        byte_done_out = 1'b0;
        rx_byte_out = 8'h00;
        retry_irq_out = 1'b0;
    end

    // Status byte goes out first after select falls
    always @(negedge slave_select_n_in) tx_q = reply_in;

    always @(posedge sclk_in)
    begin
        sh_q = {sh_q[6:0], mosi_in};
        cnt_q = cnt_q + 3'h1;
        if (cnt_q == 3'h0)
        begin
            rx_byte_out = sh_q;
            byte_done_out = 1'b1;
            #1 byte_done_out = 1'b0;
        end
    end

    always @(negedge sclk_in)
    begin
        if (cnt_q == 3'h0)
            tx_q = reply_in;
        else
            tx_q = {tx_q[6:0], ~tx_q[7]};
    end

    // Deselected line shows the inverse, never a stale level
    assign miso_out = slave_select_n_in ? ~tx_q[7] : tx_q[7];

    // Event held, payload kept, until chip enable rises again
    always @(posedge fire_retry_in or posedge chip_enable_in)
        retry_irq_out = fire_retry_in;

endmodule // rsm_radio_model

//--- sim/test_radio_spi_master_port.sv
/*
 * Self-checking bench for the radio link SPI master port.
 * Assumes the transceiver model in rsm_radio_model.sv.
 */
`timescale 1ns/100ps
module test_radio_spi_master_port;
    logic        core_clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [7:0]  sfr_addr_in = 8'h00;
    logic        sfr_wr_in = 1'b0;
    logic        sfr_rd_in = 1'b0;
    logic [7:0]  sfr_wdata_in = 8'h00;
    logic [7:0]  sfr_rdata_out;
    logic        miso, retry_irq, sclk, mosi, ss_n, ce, cg, retry, irq;
    logic [7:0]  reply = 8'h00;
    logic        fire = 1'b0;
    logic        byte_done;
    logic [7:0]  rx_byte;
    int          err_count = 0;
    int          check_count = 0;
    int          cycles = 0;
    logic [31:0] seed = 32'h0000f765;
    logic [7:0]  rdq[$];
    logic [7:0]  txq[$];
    logic [7:0]  rxq[$];
    logic        rd_seen = 1'b0;

    always #5 core_clk_in = ~core_clk_in;

    rsm_radio_spi_port rsm_radio_spi_port_i (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
        .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in),
        .sfr_rdata_out(sfr_rdata_out), .spi_miso_in(miso),
        .retry_limit_irq_in(retry_irq), .spi_sclk_out(sclk),
        .spi_mosi_out(mosi), .slave_select_n_out(ss_n),
        .chip_enable_out(ce), .clock_gate_out(cg),
        .retry_limit_out(retry), .irq_out(irq));

    rsm_radio_model rsm_radio_model_i (
        .sclk_in(sclk), .mosi_in(mosi), .slave_select_n_in(ss_n),
        .chip_enable_in(ce), .reply_in(reply), .fire_retry_in(fire),
        .miso_out(miso), .retry_irq_out(retry_irq),
        .byte_done_out(byte_done), .rx_byte_out(rx_byte));

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // One strobe cycle; for a read, d is the expected data
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge core_clk_in);
        #1;
        if (!w)
            rdq.push_back(d);
        sfr_addr_in = a;
        sfr_wdata_in = d;
        sfr_wr_in = w;
        sfr_rd_in = !w;
        @(posedge core_clk_in);
        #1;
        sfr_wr_in = 1'b0;
        sfr_rd_in = 1'b0;
    endtask

    task automatic send();
        logic [7:0] b;
        b = rnd();
        txq.push_back(b);
        bus(1'b1, 8'he7, b);
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        // Let a new mask reach the interrupt flop before polling
        repeat (2) @(posedge core_clk_in);
        while (irq !== 1'b1 && n < 500)
        begin
            @(posedge core_clk_in);
            n++;
        end
        check({7'h00, irq}, 8'h01);
    endtask

    // ------------------------------------------------------------
    // Result watchers
    // ------------------------------------------------------------
    always @(posedge core_clk_in)
    begin
        if (rd_seen)
            check(sfr_rdata_out, rdq.pop_front());
        rd_seen <= sfr_rd_in;
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            stop_test();
        end
    end

    always @(posedge byte_done)
    begin
        check(rx_byte, txq.pop_front());
        rxq.push_back(reply);
        reply = rnd();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        reply = rnd();
        repeat (20) @(posedge core_clk_in);
        #1 rst_n_in = 1'b1;
        check({5'h00, cg, ss_n, ce}, 8'h02);
        bus(1'b0, 8'he4, 8'h01);
        bus(1'b0, 8'he5, 8'h0f);
        bus(1'b0, 8'he6, rsm_pkg::RSM_FLAGS_RST);
        bus(1'b0, 8'he7, 8'h00);
        bus(1'b1, 8'h10, 8'hff);
        bus(1'b0, 8'h10, 8'h00);
        bus(1'b1, 8'he6, 8'hff);
        bus(1'b0, 8'he6, 8'h03);
        bus(1'b1, 8'he5, 8'hff);
        bus(1'b0, 8'he5, 8'h0f);
        bus(1'b1, 8'he5, 8'h0e);
        wait_irq();
        bus(1'b1, 8'he5, 8'h0d);
        wait_irq();
        bus(1'b1, 8'he5, 8'h03);
        repeat (3) @(posedge core_clk_in);
        check({7'h00, irq}, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b1, 8'he8, 8'(i));
            bus(1'b0, 8'he8, 8'(i));
            check({5'h00, cg, ss_n, ce}, 8'(i));
        end
        bus(1'b1, 8'he8, 8'hff);
        bus(1'b0, 8'he8, 8'h07);
        bus(1'b1, 8'he8, 8'h05);
        bus(1'b1, 8'he5, 8'h07);
        send();
        send();
        wait_irq();
        bus(1'b0, 8'he6, 8'h0f);
        send();
        send();
        bus(1'b1, 8'he7, rnd());
        bus(1'b0, 8'he6, 8'h0c);
        bus(1'b0, 8'he7, rxq.pop_front());
        bus(1'b0, 8'he7, rxq.pop_front());
        wait_irq();
        bus(1'b0, 8'he7, rxq.pop_front());
        bus(1'b0, 8'he7, rxq.pop_front());
        bus(1'b0, 8'he7, 8'h00);
        bus(1'b0, 8'he6, 8'h03);
        check(8'(txq.size()), 8'h00);
        fire = 1'b1;
        repeat (4) @(posedge core_clk_in);
        check({7'h00, retry}, 8'h01);
        #1 fire = 1'b0;
        bus(1'b1, 8'he8, 8'h04);
        bus(1'b1, 8'he8, 8'h05);
        repeat (4) @(posedge core_clk_in);
        check({7'h00, retry}, 8'h00);
        stop_test();
    end

endmodule // test_radio_spi_master_port
